//--- inc/css_regs.vh
// Purpose: constants for the core stack, status and data memory block
// Assumes: 8-bit data path, 7-bit data addresses
// Notes: included by logic/css_core.v
`ifndef CSS_REGS_VH
`define CSS_REGS_VH
`define CSS_ADDR_IND0 7'h00
`define CSS_ADDR_PTR0 7'h01
`define CSS_ADDR_IND1 7'h02
`define CSS_ADDR_PTR1 7'h03
`define CSS_ADDR_WREG 7'h05
`define CSS_ADDR_FLAGS 7'h0A
`define CSS_ADDR_IRQC 7'h0B
`define CSS_GP_FIRST 7'h28
`define CSS_GP_LAST 7'h7F
`define CSS_BIT_C 0
`define CSS_BIT_HC 1
`define CSS_BIT_Z 2
`define CSS_BIT_WRAP 3
`define CSS_BIT_HALTED 4
`define CSS_BIT_DOG 5
`define CSS_BIT_GIE 0
`define CSS_BIT_EXT_FLAG 4
`define CSS_BIT_TMR_FLAG 5
`define CSS_BIT_ADC_FLAG 6
`define CSS_VEC_EXT 11'h004
`define CSS_VEC_TMR 11'h008
`define CSS_VEC_ADC 11'h00C
`define CSS_OP_ADD 4'h0
`define CSS_OP_ADC 4'h1
`define CSS_OP_SUB 4'h2
`define CSS_OP_SBC 4'h3
`define CSS_OP_DAA 4'h4
`define CSS_OP_AND 4'h5
`define CSS_OP_OR 4'h6
`define CSS_OP_XOR 4'h7
`define CSS_OP_CPL 4'h8
`define CSS_OP_RL 4'h9
`define CSS_OP_RR 4'hA
`define CSS_OP_RLC 4'hB
`define CSS_OP_RRC 4'hC
`define CSS_OP_INC 4'hD
`define CSS_OP_DEC 4'hE
`define CSS_OP_PASS 4'hF
`endif

//--- logic/css_core.v
// Purpose: return stack, data memory map, flags and irq gating
// Assumes: decoder drives one-cycle strobes on i_clock
// Notes: one operation per cycle; push, pop and mem ops are exclusive
// What this block does
// - six-entry pc stack, not software visible
// - call or irq pushes, returns pop pc
// - reset points stack index at bottom
// - full stack latches flag, withholds acknowledge
// - call when full drops oldest entry
// - 128-byte map, storage at 28H-7FH
// - reserved low addresses read 00H
// - bit set/clear and alu on any location
// - 00H and 02H access via pointers
// - pointer to indirect port: read 00H, no write
// - both memory pointers seven bits wide
// - alu ops update status flags
// - working register mapped at 05H
// - software writes leave watchdog and halt bits unchanged
// - bit 0 carry or no borrow
// - bit 1 nibble carry or no borrow
// - bit 2 set on zero result
// - bit 3 set on carry in xor out
// - bit 4 cleared by kick, set by halt
// - bit 5 set only by watchdog time-out
// - flags never stacked automatically
// - servicing clears global gate
// - priority external, timer, converter with vectors
// - irq control at 0BH layout
// - irq exit sets gate, sub exit not
`timescale 1ns/100ps
`default_nettype none
`include "css_regs.vh"
module css_core #(
  parameter PC_W = 11,
  parameter DEPTH = 6
) (
  // clock and reset
  input wire i_clock,
  input wire i_nrst,
  // stack and sequencer
  input wire i_call,
  input wire i_sub_exit,
  input wire i_irq_exit,
  input wire [PC_W-1:0] i_pc,
  output reg [PC_W-1:0] o_ret_pc,
  output reg o_ret_valid,
  output reg o_stack_full,
  // data memory operation
  input wire i_mem_rd,
  input wire i_mem_wr,
  input wire i_alu_en,
  input wire i_bit_set,
  input wire i_bit_zero_instr,
  input wire [6:0] i_addr,
  input wire [2:0] i_bit,
  input wire [3:0] i_op,
  input wire i_op_imm,
  input wire i_dest_wreg,
  input wire [7:0] i_imm,
  output reg [7:0] o_rdata,
  output reg o_skip_zero,
  // power and watchdog events
  input wire i_halt,
  input wire i_dog_kick_instr,
  input wire i_dog_timeout,
  // interrupt sources, same clock domain
  input wire i_ext_req,
  input wire i_tmr_req,
  input wire i_adc_req,
  input wire i_irq_allow,
  output reg o_irq_ack,
  output reg [PC_W-1:0] o_irq_vector,
  // working register view
  output reg [7:0] o_working_register
);
  // storage size follows the general-purpose window
  localparam GP_N = `CSS_GP_LAST - `CSS_GP_FIRST + 7'h01;
  // stack has no data-map address, so no read path exists
  reg [PC_W-1:0] stk [0:DEPTH-1];
  reg [7:0] ram [0:GP_N-1];
  reg [2:0] stack_index;
  reg [6:0] pointer_zero;
  reg [6:0] pointer_one;
  reg [7:0] working_register;
  reg [5:0] flags;
  reg [6:0] irq_control;
  reg [7:0] rd_val;
  reg [7:0] alu_a;
  reg [7:0] alu_b;
  reg [7:0] alu_res;
  reg [8:0] sum;
  reg [4:0] lo;
  reg [7:0] next_val;
  reg [5:0] next_flags;
  reg c_in7;
  reg eff_null;
  reg [6:0] eff;
  integer k;

  function is_gp;
    input [6:0] a;
    begin
      is_gp = (a >= `CSS_GP_FIRST);
    end
  endfunction

  always @* begin
    if (i_addr == `CSS_ADDR_IND0) begin
      eff = pointer_zero;
    end else if (i_addr == `CSS_ADDR_IND1) begin
      eff = pointer_one;
    end else begin
      eff = i_addr;
    end
  end
  // a pointer aimed at a port reads zero and blocks stores
  // pointer at indirect port
  always @* begin
    eff_null = (i_addr == `CSS_ADDR_IND0 || i_addr == `CSS_ADDR_IND1) &&
      (eff == `CSS_ADDR_IND0 || eff == `CSS_ADDR_IND1);
  end

  // pointers read back with bit 7 clear
  // reserved reads zero
  always @* begin
    if (eff_null) begin
      rd_val = 8'h00;
    end else if (is_gp(eff)) begin
      rd_val = ram[eff - `CSS_GP_FIRST];
    end else if (eff == `CSS_ADDR_PTR0) begin
      rd_val = {1'b0, pointer_zero};
    end else if (eff == `CSS_ADDR_PTR1) begin
      rd_val = {1'b0, pointer_one};
    end else if (eff == `CSS_ADDR_WREG) begin
      rd_val = working_register;
    end else if (eff == `CSS_ADDR_FLAGS) begin
      rd_val = {2'b00, flags};
    end else if (eff == `CSS_ADDR_IRQC) begin
      rd_val = {1'b0, irq_control};
    end else begin
      rd_val = 8'h00;
    end
  end

  always @* begin
    alu_a = i_op_imm ? i_imm : rd_val;
    alu_b = working_register;
    alu_res = alu_a;
    sum = 9'h000;
    lo = 5'h00;
    c_in7 = 1'b0;
    next_flags = flags;
    case (i_op)
      `CSS_OP_ADD, `CSS_OP_ADC: begin
        sum = {1'b0, alu_a} + {1'b0, alu_b} +
          {8'h00, i_op == `CSS_OP_ADC && flags[`CSS_BIT_C]};
        lo = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} +
          {4'h0, i_op == `CSS_OP_ADC && flags[`CSS_BIT_C]};
        c_in7 = alu_a[7] ^ alu_b[7] ^ sum[7];
      end
      `CSS_OP_SUB, `CSS_OP_SBC: begin
        // a minus b done as a plus ~b plus carry, so carry means no borrow
        sum = {1'b0, alu_a} + {1'b0, ~alu_b} +
          {8'h00, i_op == `CSS_OP_SUB || flags[`CSS_BIT_C]};
        lo = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} +
          {4'h0, i_op == `CSS_OP_SUB || flags[`CSS_BIT_C]};
        c_in7 = alu_a[7] ^ ~alu_b[7] ^ sum[7];
      end
      default: begin
        sum = 9'h000;
      end
    endcase
    case (i_op)
      `CSS_OP_ADD, `CSS_OP_ADC, `CSS_OP_SUB, `CSS_OP_SBC: begin
        alu_res = sum[7:0];
        next_flags[`CSS_BIT_C] = sum[8];
        next_flags[`CSS_BIT_HC] = lo[4];
        next_flags[`CSS_BIT_WRAP] = c_in7 ^ sum[8];
      end
      `CSS_OP_DAA: begin
        // adjusts the working register, not the operand
        sum = {1'b0, alu_b};
        if (alu_b[3:0] > 4'h9 || flags[`CSS_BIT_HC]) begin
          sum = sum + 9'h006;
        end
        if (sum[7:4] > 4'h9 || flags[`CSS_BIT_C] || sum[8]) begin
          sum = sum + 9'h060;
        end
        alu_res = sum[7:0];
        next_flags[`CSS_BIT_C] = sum[8] | flags[`CSS_BIT_C];
      end
      `CSS_OP_AND: alu_res = alu_a & alu_b;
      `CSS_OP_OR: alu_res = alu_a | alu_b;
      `CSS_OP_XOR: alu_res = alu_a ^ alu_b;
      `CSS_OP_CPL: alu_res = ~alu_a;
      `CSS_OP_RL: alu_res = {alu_a[6:0], alu_a[7]};
      `CSS_OP_RR: alu_res = {alu_a[0], alu_a[7:1]};
      `CSS_OP_RLC: begin
        alu_res = {alu_a[6:0], flags[`CSS_BIT_C]};
        next_flags[`CSS_BIT_C] = alu_a[7];
      end
      `CSS_OP_RRC: begin
        alu_res = {flags[`CSS_BIT_C], alu_a[7:1]};
        next_flags[`CSS_BIT_C] = alu_a[0];
      end
      `CSS_OP_INC: alu_res = alu_a + 8'h01;
      `CSS_OP_DEC: alu_res = alu_a - 8'h01;
      default: alu_res = alu_a;
    endcase
    // rotates and pass keep the zero flag as it was
    // zero bit
    if (i_op != `CSS_OP_RL && i_op != `CSS_OP_RR && i_op != `CSS_OP_RLC &&
        i_op != `CSS_OP_RRC && i_op != `CSS_OP_PASS) begin
      next_flags[`CSS_BIT_Z] = (alu_res == 8'h00);
    end
  end

  always @* begin
    if (i_bit_set || i_bit_zero_instr) begin
      next_val = rd_val;
      next_val[i_bit] = i_bit_set;
    end else if (i_alu_en) begin
      next_val = alu_res;
    end else begin
      next_val = working_register;
    end
  end

  wire mem_store = (i_mem_wr || i_bit_set || i_bit_zero_instr ||
    (i_alu_en && !i_dest_wreg)) && !eff_null;
  wire stk_full = (stack_index == DEPTH[2:0]);
  wire any_pop = i_sub_exit || i_irq_exit;
  wire [2:0] pend = irq_control[6:4] & irq_control[3:1];
  // call, pop or store wins the cycle; the request stays pending
  // hold off when full
  wire take_irq = irq_control[`CSS_BIT_GIE] && (pend != 3'b000) &&
    !stk_full && i_irq_allow && !i_call && !any_pop && !mem_store;

  // no reset on storage; contents undefined after power-up
  // general storage
  always @(posedge i_clock) begin
    if (mem_store && is_gp(eff)) begin
      ram[eff - `CSS_GP_FIRST] <= next_val;
    end
  end

  always @(posedge i_clock) begin
    if ((i_call || take_irq) && stk_full) begin
      // index stays at the top; oldest address falls off
      // drop oldest
      for (k = 0; k < DEPTH - 1; k = k + 1) begin
        stk[k] <= stk[k + 1];
      end
      stk[DEPTH-1] <= i_pc;
    end else if (i_call || take_irq) begin
      stk[stack_index] <= i_pc;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      stack_index <= 3'h0;
      pointer_zero <= 7'h00;
      pointer_one <= 7'h00;
      working_register <= 8'h00;
      flags <= 6'h00;
      irq_control <= 7'h00;
      o_ret_pc <= {PC_W{1'b0}};
      o_ret_valid <= 1'b0;
      o_stack_full <= 1'b0;
      o_rdata <= 8'h00;
      o_skip_zero <= 1'b0;
      o_irq_ack <= 1'b0;
      o_irq_vector <= {PC_W{1'b0}};
      o_working_register <= 8'h00;
    end else begin
      o_ret_valid <= 1'b0;
      o_irq_ack <= 1'b0;
      // read data follows the address every cycle, strobe or not
      o_rdata <= rd_val;
      o_skip_zero <= (i_alu_en && alu_res == 8'h00);
      if (any_pop && stack_index != 3'h0) begin
        o_ret_pc <= stk[stack_index - 3'h1];
        o_ret_valid <= 1'b1;
        stack_index <= stack_index - 3'h1;
        o_stack_full <= 1'b0;
      end else if ((i_call || take_irq) && !stk_full) begin
        stack_index <= stack_index + 3'h1;
        o_stack_full <= (stack_index + 3'h1 == DEPTH[2:0]);
      end
      if (mem_store && eff == `CSS_ADDR_PTR0) begin
        pointer_zero <= next_val[6:0];
      end
      if (mem_store && eff == `CSS_ADDR_PTR1) begin
        pointer_one <= next_val[6:0];
      end
      if ((mem_store && eff == `CSS_ADDR_WREG) ||
          (i_alu_en && i_dest_wreg)) begin
        working_register <= (i_alu_en && i_dest_wreg) ? alu_res : next_val;
        o_working_register <= (i_alu_en && i_dest_wreg) ? alu_res :
          next_val;
      end else if (i_mem_rd && i_dest_wreg) begin
        working_register <= rd_val;
        o_working_register <= rd_val;
      end
      if (mem_store && eff == `CSS_ADDR_FLAGS) begin
        flags[3:0] <= next_val[3:0];
      end else if (i_alu_en) begin
        flags[3:0] <= next_flags[3:0];
      end
      // set beats clear should both ever land together
      // halt bit
      if (i_halt) begin
        flags[`CSS_BIT_HALTED] <= 1'b1;
      end else if (i_dog_kick_instr) begin
        flags[`CSS_BIT_HALTED] <= 1'b0;
      end
      if (i_dog_timeout) begin
        flags[`CSS_BIT_DOG] <= 1'b1;
      end else if (i_dog_kick_instr || i_halt) begin
        flags[`CSS_BIT_DOG] <= 1'b0;
      end
      // control layout; request set beats software clear
      if (mem_store && eff == `CSS_ADDR_IRQC) begin
        irq_control <= next_val[6:0] |
          {i_adc_req, i_tmr_req, i_ext_req, 4'h0};
      end else begin
        irq_control[6:4] <= irq_control[6:4] |
          {i_adc_req, i_tmr_req, i_ext_req};
        if (i_irq_exit) begin
          irq_control[`CSS_BIT_GIE] <= 1'b1;
        end
        if (take_irq) begin
          irq_control[`CSS_BIT_GIE] <= 1'b0;
          o_irq_ack <= 1'b1;
          // a request in the service cycle keeps its flag
          // fixed priority
          if (pend[0]) begin
            irq_control[`CSS_BIT_EXT_FLAG] <= 1'b0;
            o_irq_vector <= `CSS_VEC_EXT;
          end else if (pend[1]) begin
            irq_control[`CSS_BIT_TMR_FLAG] <= i_tmr_req;
            o_irq_vector <= `CSS_VEC_TMR;
          end else begin
            irq_control[`CSS_BIT_ADC_FLAG] <= i_adc_req;
            o_irq_vector <= `CSS_VEC_ADC;
          end
          if (pend[0]) begin
            irq_control[`CSS_BIT_EXT_FLAG] <= i_ext_req;
          end
        end
      end
    end
  end
endmodule // css_core
`default_nettype wire

//--- verification/css_seq_model.sv
// Purpose: sequencer stand-in feeding pc and irq window
// Assumes: one instruction per clock
// Notes: pc only feeds stack pushes
`timescale 1ns/100ps
`default_nettype none
module css_seq_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // sequencer view
  output logic [10:0] o_pc,
  output logic o_irq_allow
);
  // pc moves every cycle so each push carries a fresh value
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pc <= 11'h000;
      o_irq_allow <= 1'b0;
    end else begin
      o_pc <= o_pc + 11'h001;
      o_irq_allow <= 1'b1;
    end
  end
endmodule // css_seq_model
`default_nettype wire

//--- verification/css_core_asserts.sv
// Purpose: port checks for css_core
// Assumes: single clock domain
// Notes: bound into every css_core
`timescale 1ns/100ps
`default_nettype none
`include "css_regs.vh"
module css_chk #(
  parameter PC_W = 11,
  parameter DEPTH = 6
) (
  // watched ports
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_call,
  input wire logic i_sub_exit,
  input wire logic i_irq_exit,
  input wire logic i_irq_allow,
  input wire logic [6:0] i_addr,
  input wire logic o_ret_valid,
  input wire logic o_stack_full,
  input wire logic o_irq_ack,
  input wire logic [PC_W-1:0] o_irq_vector,
  input wire logic [7:0] o_rdata
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  sequence full_pop;
    o_stack_full && (i_sub_exit || i_irq_exit);
  endsequence
  ret_cause_a :
    assert property (o_ret_valid |-> $past(i_sub_exit || i_irq_exit))
    else $error("return pulse without exit");
  reset_top_a :
    assert property ($rose(i_nrst) |-> !o_stack_full)
    else $error("stack full after reset");
  full_pop_a :
    assert property (full_pop |=> !o_stack_full)
    else $error("pop left stack full");
  ack_room_a :
    assert property (o_irq_ack |-> !$past(o_stack_full) && $past(i_irq_allow))
    else $error("ack while stack full");
  call_full_a :
    assert property (o_stack_full && i_call |=> o_stack_full)
    else $error("call on full stack lost full");
  ack_once_a :
    assert property (o_irq_ack |=> !o_irq_ack)
    else $error("second ack while gate closed");
  vec_legal_a :
    assert property (o_irq_ack |-> o_irq_vector inside
      {`CSS_VEC_EXT, `CSS_VEC_TMR, `CSS_VEC_ADC})
    else $error("bad irq vector");
  resv_zero_a :
    assert property (i_addr inside {7'h04, 7'h09, 7'h0C, [7'h24:7'h27]}
      |=> o_rdata == 8'h00)
    else $error("reserved byte not zero");
  flag_top_a :
    assert property (i_addr == `CSS_ADDR_FLAGS |=> o_rdata[7:6] == 2'b00)
    else $error("status top bits set");
endmodule // css_chk
bind css_core css_chk #(.PC_W(PC_W), .DEPTH(DEPTH)) u_chk (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_call(i_call),
  .i_sub_exit(i_sub_exit), .i_irq_exit(i_irq_exit),
  .i_irq_allow(i_irq_allow), .i_addr(i_addr), .o_ret_valid(o_ret_valid),
  .o_stack_full(o_stack_full), .o_irq_ack(o_irq_ack),
  .o_irq_vector(o_irq_vector), .o_rdata(o_rdata));
`default_nettype wire

//--- verification/css_core_tb_top.sv
// Purpose: self-checking bench for css_core
// Assumes: 125 MHz clock, one strobe per cycle
// Notes: integer model of stack, map and flags runs alongside
`timescale 1ns/100ps
`default_nettype none
`include "css_regs.vh"
module css_core_tb_top;
  logic i_clock;
  logic i_nrst;
  logic [13:0] stb;
  logic [6:0] i_addr;
  logic [2:0] i_bit;
  logic [3:0] i_op;
  logic [7:0] i_imm;
  logic i_op_imm;
  logic i_dest_wreg;
  wire i_call, i_sub_exit, i_irq_exit, i_mem_rd, i_mem_wr, i_alu_en;
  wire i_bit_set, i_bit_zero_instr, i_halt, i_dog_kick_instr;
  wire i_dog_timeout, i_ext_req, i_tmr_req, i_adc_req, i_irq_allow;
  wire o_ret_valid, o_stack_full, o_skip_zero, o_irq_ack;
  wire [10:0] i_pc, o_ret_pc, o_irq_vector;
  wire [7:0] o_rdata, o_working_register;
  int failures, cmp_count, seed, k, p, c, w, r;
  int stk[$];
  int mem[128];
  localparam logic [13:0] CALL = 14'h2000, SUBX = 14'h1000;
  localparam logic [13:0] IRQX = 14'h0800, RD = 14'h0400, WR = 14'h0200;
  localparam logic [13:0] ALU = 14'h0100, SETB = 14'h0080;
  localparam logic [13:0] CLRB = 14'h0040, HALT = 14'h0020;
  localparam logic [13:0] KICK = 14'h0010, DOG = 14'h0008, ADC = 14'h0001;
  assign {i_call, i_sub_exit, i_irq_exit, i_mem_rd, i_mem_wr, i_alu_en,
    i_bit_set, i_bit_zero_instr, i_halt, i_dog_kick_instr, i_dog_timeout,
    i_ext_req, i_tmr_req, i_adc_req} = stb;
  css_core #(.PC_W(11), .DEPTH(6)) dut (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_call(i_call), .i_sub_exit(i_sub_exit), .i_irq_exit(i_irq_exit),
    .i_pc(i_pc), .o_ret_pc(o_ret_pc), .o_ret_valid(o_ret_valid),
    .o_stack_full(o_stack_full), .i_mem_rd(i_mem_rd), .i_mem_wr(i_mem_wr),
    .i_alu_en(i_alu_en), .i_bit_set(i_bit_set), .i_addr(i_addr),
    .i_bit_zero_instr(i_bit_zero_instr), .i_bit(i_bit), .i_op(i_op),
    .i_op_imm(i_op_imm), .i_dest_wreg(i_dest_wreg), .i_imm(i_imm),
    .o_rdata(o_rdata), .o_skip_zero(o_skip_zero), .i_halt(i_halt),
    .i_dog_kick_instr(i_dog_kick_instr), .i_dog_timeout(i_dog_timeout),
    .i_ext_req(i_ext_req), .i_tmr_req(i_tmr_req), .i_adc_req(i_adc_req),
    .i_irq_allow(i_irq_allow), .o_irq_ack(o_irq_ack),
    .o_irq_vector(o_irq_vector), .o_working_register(o_working_register));
  css_seq_model u_seq (.i_clock(i_clock), .i_nrst(i_nrst), .o_pc(i_pc),
    .o_irq_allow(i_irq_allow));
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  task automatic test_done;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp,
    input string nm);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe held one cycle; pc captured mid-cycle for the stack model
  task automatic op(input logic [13:0] s, input int a, input int d);
    @(posedge i_clock);
    stb <= s;
    i_addr <= a[6:0];
    i_imm <= d[7:0];
    @(negedge i_clock);
    p = i_pc;
    @(posedge i_clock);
    stb <= 14'h0000;
    #1;
  endtask
  function automatic int ea(int a);
    return a == 0 ? mem[1] : a == 2 ? mem[3] : a;
  endfunction
  function automatic int mrd(int a);
    return ea(a) == 0 || ea(a) == 2 ? 0 : mem[ea(a)];
  endfunction
  task automatic mwr(int a, int v);
    int e;
    e = ea(a);
    if (e == 10)
      mem[10] = mem[10] & 8'h30 | v & 8'h0F;
    else if (e == 1 || e == 3 || e == 11)
      mem[e] = v & 8'h7F;
    else if (e == 5 || e >= 8'h28)
      mem[e] = v & 8'hFF;
  endtask
  task automatic ld(input int v);
    i_op <= `CSS_OP_PASS;
    i_op_imm <= 1'b1;
    i_dest_wreg <= 1'b1;
    op(ALU, 0, v);
    mem[5] = v & 8'hFF;
  endtask
  task automatic wr(input int a, input int v);
    ld(v);
    op(WR, a, 0);
    mwr(a, v);
  endtask
  task automatic rd(input int a, input int e);
    i_dest_wreg <= 1'b0;
    op(RD, a, 0);
    chk(o_rdata, e, "rdata");
  endtask
  // rotates and pass leave zero flag alone
  function automatic int alu(int o, int a, int b);
    int ci, r, t;
    ci = mem[10] & 1;
    // subtraction is operand minus working register
    if (o > 1 && o < 4) begin
      t = b;
      b = ~a & 8'hFF;
      a = t;
    end
    ci = o == 0 ? 0 : o == 2 ? 1 : ci;
    case (o)
      0, 1, 2, 3: begin
        r = a + b + ci;
        mem[10] = mem[10] & 8'h30 | r >> 8 | ((a & 15) + (b & 15) + ci) >> 4 << 1
          | (((a & 127) + (b & 127) + ci) >> 7 ^ r >> 8) << 3;
      end
      4: begin
        r = a;
        if ((r & 15) > 9 || (mem[10] & 2) != 0)
          r = r + 6;
        if ((r >> 4 & 15) > 9 || ci != 0 || r > 255)
          r = r + 8'h60;
        mem[10] = mem[10] & 8'h3E | ci | r >> 8;
      end
      5: r = a & b;
      6: r = a | b;
      7: r = a ^ b;
      8: r = ~b;
      9: r = b << 1 | b >> 7;
      10: r = b >> 1 | b << 7;
      11: begin
        r = b << 1 | ci;
        mem[10] = mem[10] & 8'h3E | b >> 7;
      end
      12: begin
        r = b >> 1 | ci << 7;
        mem[10] = mem[10] & 8'h3E | b & 1;
      end
      13: r = b + 1;
      14: r = b - 1;
      default: r = b;
    endcase
    r = r & 8'hFF;
    if (o < 9 || o == 13 || o == 14)
      mem[10] = mem[10] & 8'h3B | (r == 0) << 2;
    return r;
  endfunction
  initial begin
    #200000;
    failures++;
    test_done;
  end
  initial begin
    seed = 32'hB7F1;
    stb = 14'h0000;
    {i_addr, i_bit, i_op, i_imm, i_op_imm, i_dest_wreg} = '0;
    i_nrst = 1'b0;
    repeat (5) @(posedge i_clock);
    i_nrst <= 1'b1;
    #1;
    chk(o_stack_full, 0, "full");
    chk(o_working_register, 0, "wreg");
    for (k = 0; k < 7; k++) begin
      op(CALL, 0, 0);
      stk.push_back(p);
      if (stk.size() > 6)
        stk.pop_front();
      chk(o_stack_full, stk.size() == 6, "full");
    end
    wr(11, 8'h09);
    op(ADC, 0, 0);
    repeat (3) begin
      @(posedge i_clock);
      #1;
      chk(o_irq_ack, 0, "ack");
    end
    rd(11, 8'h49);
    op(SUBX, 0, 0);
    chk(o_ret_pc, stk.pop_back(), "retpc");
    @(posedge i_clock);
    #1;
    chk(o_irq_ack, 1, "ack");
    chk(o_irq_vector, `CSS_VEC_ADC, "vector");
    mem[11] = 8'h08;
    op(IRQX, 0, 0);
    mem[11] = 8'h09;
    rd(11, 8'h09);
    while (stk.size() > 0) begin
      op(SUBX, 0, 0);
      chk(o_ret_pc, stk.pop_back(), "retpc");
    end
    op(SUBX, 0, 0);
    chk(o_ret_valid, 0, "pop");
    wr(11, 8'h7F);
    for (k = 0; k < 3; k++) begin
      @(posedge i_clock);
      #1;
      chk(o_irq_ack, 1, "ack");
      chk(o_irq_vector, 4 + 4 * k, "vector");
      @(posedge i_clock);
      #1;
      chk(o_irq_ack, 0, "ack");
      op(IRQX, 0, 0);
      chk(o_ret_valid, 1, "pop");
    end
    mem[11] = 8'h0F;
    rd(11, mem[11]);
    for (k = 0; k < 8; k++) begin
      r = 8'h28 + {$random(seed)} % 88;
      wr(1, r);
      wr(3, r);
      wr(0, $random(seed));
      rd(2, mrd(2));
      rd(r, mrd(r));
      i_bit <= k[2:0];
      op(k[0] ? SETB : CLRB, r, 0);
      mem[r] = k[0] ? mem[r] | 1 << k : mem[r] & ~(1 << k);
      rd(r, mem[r]);
    end
    i_op <= `CSS_OP_INC;
    i_op_imm <= 1'b0;
    i_dest_wreg <= 1'b0;
    op(ALU, r, 0);
    mem[r] = mem[r] + 1 & 8'hFF;
    rd(r, mem[r]);
    wr(1, 8'hFF);
    rd(1, 8'h7F);
    wr(1, 0);
    wr(0, 8'h55);
    rd(0, 0);
    rd(8'h27, 0);
    wr(5, 8'hA6);
    chk(o_working_register, 8'hA6, "wreg");
    wr(10, 8'hFF);
    rd(10, mem[10]);
    op(DOG, 0, 0);
    rd(10, mem[10] | 8'h20);
    op(HALT, 0, 0);
    rd(10, mem[10] | 8'h10);
    op(KICK, 0, 0);
    rd(10, mem[10]);
    for (k = 0; k < 48; k++) begin
      wr(10, $random(seed));
      r = k < 16 ? 8'hFF : $random(seed) & 8'hFF;
      ld(r);
      w = k < 16 ? 1 : $random(seed) & 8'hFF;
      i_op <= k[3:0];
      op(ALU, 0, w);
      c = alu(k % 16, r, w);
      mem[5] = c;
      chk(o_working_register, c, "wreg");
      chk(o_skip_zero, c == 0, "skip");
      rd(10, mem[10]);
    end
    test_done;
  end
endmodule // css_core_tb_top
`default_nettype wire
